// file: design/sem_host_pkg.sv
// package for the semaphore host controller: command register map, pin bundle, timing
// assumes one clock at 125 MHz and a dual-port memory's semaphore pins on one port
package sem_host_pkg;
	localparam int unsigned CLK_MHZ      = 125;
	localparam int unsigned ADDR_W       = 8;
	localparam int unsigned DATA_W       = 16;
	localparam int unsigned FLAG_W       = 3;
	localparam int unsigned FLAG_COUNT   = 8;
	// access strobe width on the device pins, in ns, rounded up to cycles
	localparam int unsigned STROBE_NS    = 40;
	localparam int unsigned STROBE_CYC   = (STROBE_NS * CLK_MHZ + 999) / 1000;
	// idle gap with select and output enable inactive between accesses
	localparam int unsigned GAP_NS       = 16;
	localparam int unsigned GAP_CYC      = (GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CNT_W        = 8;

	// command register offsets
	localparam logic [ADDR_W-1:0] CMD_OFF    = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h04;
	localparam logic [ADDR_W-1:0] OWNED_OFF  = 8'h08;
	// command word fields
	localparam int unsigned CMD_IDX_LSB  = 0;
	localparam int unsigned CMD_OP_LSB   = 4;
	localparam int unsigned CMD_OP_W     = 2;
	// status word fields
	localparam int unsigned ST_BUSY_BIT  = 0;
	localparam int unsigned ST_GOT_BIT   = 1;
	localparam int unsigned ST_INIT_BIT  = 2;
	localparam int unsigned ST_VAL_LSB   = 16;

	typedef enum logic [1:0] {
		OP_ACQUIRE = 2'b00,
		OP_RELEASE = 2'b01,
		OP_READ    = 2'b10,
		OP_INIT    = 2'b11
	} op_t;

	// one port's semaphore pins as seen from the controller
	typedef struct packed {
		logic              semaphore_select_n;
		logic              chip_enable_n;
		logic              write_n;
		logic              output_enable_n;
		logic [FLAG_W-1:0] flag_index;
		logic [DATA_W-1:0] data_out;
		logic              data_oe;
	} sem_pins_t;
endpackage

// file: design/sem_host.sv
// host controller driving one port's semaphore flags of a dual-port memory
// assumes data lines are synchronous to ref_clk_i and the device answers within the strobe time
`timescale 1ns/1ns
module sem_host (
	input  wire logic                                ref_clk_i,
	input  wire logic                                sys_rst_i,
	input  wire logic                                clk_en_i,
	input  wire logic [sem_host_pkg::ADDR_W-1:0]     reg_addr_i,
	input  wire logic [31:0]                         reg_wdata_i,
	input  wire logic                                reg_wr_i,
	input  wire logic                                reg_rd_i,
	output logic      [31:0]                         reg_rdata_o,
	output logic                                     semaphore_select_n_o,
	output logic                                     chip_enable_n_o,
	output logic                                     write_n_o,
	output logic                                     output_enable_n_o,
	output logic      [sem_host_pkg::FLAG_W-1:0]     flag_index_o,
	output logic      [sem_host_pkg::DATA_W-1:0]     port_data_lines_o,
	output logic                                     port_data_lines_oe_o,
	input  wire logic [sem_host_pkg::DATA_W-1:0]     port_data_lines_i
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_WRITE = 3'b001,
		ST_GAP   = 3'b010,
		ST_READ  = 3'b011,
		ST_DONE  = 3'b100
	} state_t;

	state_t                                state_reg, state_next;
	sem_host_pkg::sem_pins_t               pins_reg, pins_next;
	sem_host_pkg::op_t                     op_reg, op_next;
	logic [sem_host_pkg::CNT_W-1:0]        cnt_reg, cnt_next;
	logic                                  busy_reg, busy_next;
	logic                                  got_reg, got_next;
	logic                                  init_reg, init_next;
	logic [sem_host_pkg::DATA_W-1:0]       val_reg, val_next;
	logic [sem_host_pkg::FLAG_COUNT-1:0]   owned_reg, owned_next;
	logic [31:0]                           rdata_reg, rdata_next;
	logic                                  write_phase;

	// a flag reads as all ones or all zeros; anything else is a glitched read, taken as not owned
	function automatic logic flag_is_ours(input logic [sem_host_pkg::DATA_W-1:0] v);
		return v == '0;
	endfunction

	// pin drive for a given phase; chip enable never low so memory is never touched
	function automatic sem_host_pkg::sem_pins_t drive(input logic active, input logic wr,
			input logic [sem_host_pkg::FLAG_W-1:0] idx, input logic bit0);
		sem_host_pkg::sem_pins_t p;
		p.semaphore_select_n = ~active;
		p.chip_enable_n      = 1'b1;
		p.write_n            = ~(active & wr);
		p.output_enable_n    = ~(active & ~wr);
		p.flag_index         = idx;
		p.data_out           = {{(sem_host_pkg::DATA_W-1){bit0}}, bit0};
		p.data_oe            = active & wr;
		return p;
	endfunction

	// only acquire, release and init begin with a write; read-only goes straight to a read
	assign write_phase = (op_reg != sem_host_pkg::OP_READ);

	// sequencer: acquire writes then reads back, release and init only write, read only reads; both strobes dropped between accesses
	always_comb begin
		state_next = state_reg;
		pins_next  = pins_reg;
		op_next    = op_reg;
		cnt_next   = cnt_reg;
		busy_next  = busy_reg;
		got_next   = got_reg;
		init_next  = init_reg;
		val_next   = val_reg;
		owned_next = owned_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (reg_wr_i && reg_addr_i == sem_host_pkg::CMD_OFF) begin
					op_next   = sem_host_pkg::op_t'(reg_wdata_i[sem_host_pkg::CMD_OP_LSB +: sem_host_pkg::CMD_OP_W]);
					pins_next.flag_index = reg_wdata_i[sem_host_pkg::CMD_IDX_LSB +: sem_host_pkg::FLAG_W];
					busy_next = 1'b1;
					got_next  = 1'b0;
					cnt_next  = '0;
					state_next = (sem_host_pkg::op_t'(reg_wdata_i[sem_host_pkg::CMD_OP_LSB +: sem_host_pkg::CMD_OP_W])
						== sem_host_pkg::OP_INIT) ? ST_WRITE : ST_GAP;
					if (sem_host_pkg::op_t'(reg_wdata_i[sem_host_pkg::CMD_OP_LSB +: sem_host_pkg::CMD_OP_W])
						== sem_host_pkg::OP_INIT)
						pins_next.flag_index = '0;
				end
			end
			ST_GAP: begin
				pins_next = drive(1'b0, 1'b0, pins_reg.flag_index, 1'b1);
				cnt_next  = cnt_reg + 1'b1;
				if (cnt_reg >= sem_host_pkg::CNT_W'(sem_host_pkg::GAP_CYC - 1)) begin
					cnt_next   = '0;
					if (write_phase && !got_reg) begin
						state_next = ST_WRITE;
						got_next   = 1'b1; // marks the write as issued
					end else
						state_next = ST_READ;
				end
			end
			ST_WRITE: begin
				// acquire writes zero; release and init write one
				pins_next = drive(1'b1, 1'b1, pins_reg.flag_index, op_reg != sem_host_pkg::OP_ACQUIRE);
				cnt_next  = cnt_reg + 1'b1;
				// first counted cycle still shows idle pins, so count the full width
				if (cnt_reg >= sem_host_pkg::CNT_W'(sem_host_pkg::STROBE_CYC)) begin
					cnt_next   = '0;
					pins_next  = drive(1'b0, 1'b1, pins_reg.flag_index, 1'b1);
					if (op_reg == sem_host_pkg::OP_INIT) begin
						owned_next[pins_reg.flag_index] = 1'b0;
						if (pins_reg.flag_index == sem_host_pkg::FLAG_W'(sem_host_pkg::FLAG_COUNT - 1)) begin
							init_next  = 1'b1;
							state_next = ST_DONE;
						end else
							pins_next.flag_index = pins_reg.flag_index + 1'b1;
					end else if (op_reg == sem_host_pkg::OP_RELEASE) begin
						owned_next[pins_reg.flag_index] = 1'b0;
						state_next = ST_DONE;
					end else
						state_next = ST_GAP; // read back after the write
				end
			end
			ST_READ: begin
				// value is latched on the device while select and enable stay low
				pins_next = drive(1'b1, 1'b0, pins_reg.flag_index, 1'b1);
				cnt_next  = cnt_reg + 1'b1;
				if (cnt_reg >= sem_host_pkg::CNT_W'(sem_host_pkg::STROBE_CYC)) begin
					cnt_next  = '0;
					val_next  = port_data_lines_i;
					got_next  = flag_is_ours(port_data_lines_i);
					if (op_reg == sem_host_pkg::OP_ACQUIRE)
						owned_next[pins_reg.flag_index] = flag_is_ours(port_data_lines_i);
					pins_next  = drive(1'b0, 1'b0, pins_reg.flag_index, 1'b1);
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				busy_next  = 1'b0;
				if (op_reg != sem_host_pkg::OP_ACQUIRE && op_reg != sem_host_pkg::OP_READ)
					got_next = 1'b0;
				state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// register read mux, data valid the cycle after the strobe
	always_comb begin
		rdata_next = '0;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				sem_host_pkg::STATUS_OFF: begin
					rdata_next[sem_host_pkg::ST_BUSY_BIT] = busy_reg;
					rdata_next[sem_host_pkg::ST_GOT_BIT]  = got_reg;
					rdata_next[sem_host_pkg::ST_INIT_BIT] = init_reg;
					rdata_next[sem_host_pkg::ST_VAL_LSB +: sem_host_pkg::DATA_W] = val_reg;
				end
				sem_host_pkg::OWNED_OFF: rdata_next[sem_host_pkg::FLAG_COUNT-1:0] = owned_reg;
				default: rdata_next = '0;
			endcase
		end
	end

	// state registers; clock enable low freezes everything
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_reg <= ST_IDLE;
			pins_reg  <= '{semaphore_select_n: 1'b1, chip_enable_n: 1'b1, write_n: 1'b1,
				output_enable_n: 1'b1, flag_index: '0, data_out: '0, data_oe: 1'b0};
			op_reg    <= sem_host_pkg::OP_READ;
			cnt_reg   <= '0;
			busy_reg  <= 1'b0;
			got_reg   <= 1'b0;
			init_reg  <= 1'b0;
			val_reg   <= '0;
			owned_reg <= '0;
			rdata_reg <= '0;
		end else if (clk_en_i) begin
			state_reg <= state_next;
			pins_reg  <= pins_next;
			op_reg    <= op_next;
			cnt_reg   <= cnt_next;
			busy_reg  <= busy_next;
			got_reg   <= got_next;
			init_reg  <= init_next;
			val_reg   <= val_next;
			owned_reg <= owned_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata_o          = rdata_reg;
	assign semaphore_select_n_o = pins_reg.semaphore_select_n;
	assign chip_enable_n_o      = pins_reg.chip_enable_n;
	assign write_n_o            = pins_reg.write_n;
	assign output_enable_n_o    = pins_reg.output_enable_n;
	assign flag_index_o         = pins_reg.flag_index;
	assign port_data_lines_o    = pins_reg.data_out;
	assign port_data_lines_oe_o = pins_reg.data_oe;
endmodule

// file: testbench/sem_host_assertions.sv
// checker on the host controller pins and register read port
// assumes clk_en_i stays high while access strobes are timed
`timescale 1ns/1ns
module sem_host_checker (
	input wire logic                          ref_clk_i,
	input wire logic                          sys_rst_i,
	input wire logic                          clk_en_i,
	input wire logic                          reg_rd_i,
	input wire logic [31:0]                   reg_rdata_o,
	input wire logic                          semaphore_select_n_o,
	input wire logic                          chip_enable_n_o,
	input wire logic                          write_n_o,
	input wire logic                          output_enable_n_o,
	input wire logic [sem_host_pkg::FLAG_W-1:0] flag_index_o,
	input wire logic [sem_host_pkg::DATA_W-1:0] port_data_lines_o,
	input wire logic                          port_data_lines_oe_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_ce_high: assert property (chip_enable_n_o)
		else $error("memory chip enable went low");
	chk_data_repl: assert property (port_data_lines_oe_o |-> port_data_lines_o inside {16'h0000, 16'hffff})
		else $error("write data not replicated");
	chk_rdata_pulse: assert property ($past(clk_en_i) && !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside its cycle");
	chk_write_drives: assert property (!semaphore_select_n_o && !write_n_o |-> port_data_lines_oe_o)
		else $error("write without driven data");
	chk_strobe_len: assert property ($fell(semaphore_select_n_o) |->
		!semaphore_select_n_o [*5] ##1 semaphore_select_n_o)
		else $error("select low length wrong");
	chk_access_stable: assert property (!semaphore_select_n_o && !$past(semaphore_select_n_o) |->
		$stable(flag_index_o) && $stable(write_n_o))
		else $error("index or direction moved in access");
	chk_one_op: assert property (!semaphore_select_n_o |-> write_n_o != output_enable_n_o)
		else $error("access is not one read or one write");
	chk_idle_pins: assert property (semaphore_select_n_o |-> write_n_o && output_enable_n_o)
		else $error("strobe active while deselected");
endmodule
bind sem_host sem_host_checker i_chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .semaphore_select_n_o(semaphore_select_n_o),
	.chip_enable_n_o(chip_enable_n_o), .write_n_o(write_n_o), .output_enable_n_o(output_enable_n_o),
	.flag_index_o(flag_index_o), .port_data_lines_o(port_data_lines_o), .port_data_lines_oe_o(port_data_lines_oe_o));

// file: testbench/sem_dev_model.sv
// device model: eight flags shared by two ports, request latches and arbiter
// assumes port a pins change after clk_i edges; port b is a one-cycle strobe from the bench
`timescale 1ns/1ns
module sem_dev_model (
	input  wire logic        clk_i,
	input  wire logic        sel_n_i,
	input  wire logic        write_n_i,
	input  wire logic        oe_n_i,
	input  wire logic [2:0]  idx_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        b_wr_i,
	input  wire logic [2:0]  b_idx_i,
	input  wire logic        b_bit_i,
	output logic      [15:0] rdata_o
);
	logic [7:0]  req_a = 8'h00; // all latches zero (requesting) at power-up
	logic [7:0]  req_b = 8'h00;
	logic [1:0]  own [8]; // eight flags, owner 0 none 1 a 2 b, gate nothing
	logic        rd_lat = 1'b1;
	logic        rd_act = 1'b0;
	logic [15:0] last = 16'h0;
	initial foreach (own[k]) own[k] = 2'd0;
	// latches, hand-over, then read capture; a wins a same-edge tie
	always @(posedge clk_i) begin
		if (!sel_n_i && !write_n_i) req_a[idx_i] = wdata_i[0];
		if (b_wr_i) req_b[b_idx_i] = b_bit_i;
		foreach (own[k]) begin
			if (own[k] == 2'd1 && req_a[k]) own[k] = req_b[k] ? 2'd0 : 2'd2;
			if (own[k] == 2'd2 && req_b[k]) own[k] = req_a[k] ? 2'd0 : 2'd1;
			if (own[k] == 2'd0) own[k] = !req_a[k] ? 2'd1 : (!req_b[k] ? 2'd2 : 2'd0);
		end
		if (!sel_n_i && !oe_n_i && !rd_act) rd_lat = (own[idx_i] != 2'd1);
		rd_act = !sel_n_i && !oe_n_i;
		// released lines toggle so a stale value is never read
		last <= rd_act ? {16{rd_lat}} : ~last;
	end
	assign rdata_o = last;
endmodule

// file: testbench/tb_top.sv
// self-checking bench: host controller against the two-port flag model
// assumes command map 0x00 cmd, 0x04 status, 0x08 owned of the host
`timescale 1ns/1ns
module tb_top;
	logic        ref_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        clk_en = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        rd_d = 1'b0;
	logic        b_wr = 1'b0;
	logic        b_bit = 1'b1;
	logic        bside;
	logic [2:0]  b_idx = 3'h0;
	logic [2:0]  f;
	logic [2:0]  idx;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] e;
	logic [31:0] m;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic        sel_n, we_n, oe_n, d_oe;
	logic [15:0] d_out, d_in;
	int          mismatches = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	initial forever #4 ref_clk_i = ~ref_clk_i;
	sem_host i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
		.semaphore_select_n_o(sel_n), .chip_enable_n_o(), .write_n_o(we_n), .output_enable_n_o(oe_n),
		.flag_index_o(idx), .port_data_lines_o(d_out), .port_data_lines_oe_o(d_oe), .port_data_lines_i(d_in));
	sem_dev_model i_dev (.clk_i(ref_clk_i), .sel_n_i(sel_n), .write_n_i(we_n), .oe_n_i(oe_n), .idx_i(idx),
		.wdata_i(d_out), .b_wr_i(b_wr), .b_idx_i(b_idx), .b_bit_i(b_bit), .rdata_o(d_in));
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		cmp_count++;
		if (seen !== expd) begin
			mismatches++;
			$display("Error reg_rdata_o expected %h seen %h", expd, seen);
		end
	endtask
	// one strobe cycle on the register port
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= wr;
		reg_rd <= !wr;
		@(posedge ref_clk_i);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask
	// note the expectation before the read goes out; zero mask means not compared
	task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] ex);
		msk_q.push_back(mask);
		exp_q.push_back(ex);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic idle();
		for (int n = 0; n < 200; n++) begin
			rd(8'h04, 32'h0, 32'h0);
			#1;
			if (rdata[0] === 1'b0)
				break;
		end
	endtask
	task automatic cmd(input logic [1:0] op, input logic [2:0] ix);
		bus(1'b1, 8'h00, {26'h0, op, 1'b0, ix});
		idle();
	endtask
	// other processor writing its own request latch
	task automatic bw(input logic [2:0] ix, input logic v);
		@(posedge ref_clk_i);
		b_wr <= 1'b1;
		b_idx <= ix;
		b_bit <= v;
		@(posedge ref_clk_i);
		b_wr <= 1'b0;
	endtask
	// watcher: oldest note against the data of the cycle after each read
	always @(posedge ref_clk_i) begin
		rd_d <= reg_rd;
		cycles++;
		if (rd_d && msk_q.size() > 0) begin
			m = msk_q.pop_front();
			e = exp_q.pop_front();
			if (m != 32'h0)
				check(rdata & m, e);
		end
		if (cycles == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		void'($urandom(32'hc1dcc502));
		repeat (20) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		rd(8'h04, 32'hffffffff, 32'h0);
		rd(8'h10, 32'hffffffff, 32'h0);
		for (int k = 0; k < 8; k++)
			bw(k[2:0], 1'b1);
		cmd(2'h3, 3'h0);
		rd(8'h04, 32'h4, 32'h4);
		$display("test reset and init done");
		cmd(2'h0, 3'h3);
		rd(8'h04, 32'h2, 32'h2);
		rd(8'h08, 32'hff, 32'h08);
		bw(3'h3, 1'b0);
		cmd(2'h2, 3'h3);
		rd(8'h04, 32'hffff0002, 32'h00000002);
		cmd(2'h1, 3'h3);
		cmd(2'h2, 3'h3);
		rd(8'h04, 32'hffff0002, 32'hffff0000);
		cmd(2'h0, 3'h3);
		rd(8'h04, 32'h2, 32'h0);
		bw(3'h3, 1'b1);
		cmd(2'h2, 3'h3);
		rd(8'h04, 32'h2, 32'h2);
		cmd(2'h1, 3'h3);
		$display("test hand-over done");
		bus(1'b1, 8'h00, 32'h00000015);
		bus(1'b1, 8'h00, 32'h00000005);
		rd(8'h04, 32'h1, 32'h1);
		idle();
		rd(8'h08, 32'h20, 32'h0);
		$display("test busy refusal done");
		// a command written while the enable is low must be lost, not started later
		clk_en <= 1'b0;
		bus(1'b1, 8'h00, 32'h00000006);
		clk_en <= 1'b1;
		rd(8'h04, 32'h1, 32'h0);
		idle();
		rd(8'h08, 32'h40, 32'h0);
		$display("test clock enable freeze done");
		for (int n = 0; n < 6; n++) begin
			f = 3'($urandom % 8);
			bside = 1'($urandom % 2);
			if (bside)
				bw(f, 1'b0);
			cmd(2'h0, f);
			rd(8'h04, 32'h2, {30'h0, !bside, 1'b0});
			cmd(2'h1, f);
			bw(f, 1'b1);
		end
		$display("test random contention done");
		finish_test();
	end
endmodule
